//--- src/wsup_pkg.sv
// constants of the window supervisor reset logic
package wsup_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DETECT_TIME_US = 450;
  localparam int unsigned DETECT_CYCLES = DETECT_TIME_US * CLK_MHZ;
  localparam int unsigned PROBE_TIME_US = 50;
  localparam int unsigned PROBE_CYCLES = PROBE_TIME_US * CLK_MHZ;
  // preset pairs in microseconds for variants 0..2, one fixed value for variant 3
  localparam int unsigned SHORT_US_V0 = 10000;
  localparam int unsigned LONG_US_V0 = 200000;
  localparam int unsigned SHORT_US_V1 = 1000;
  localparam int unsigned LONG_US_V1 = 20000;
  localparam int unsigned SHORT_US_V2 = 5000;
  localparam int unsigned LONG_US_V2 = 100000;
  localparam int unsigned FIXED_US_V3 = 50;
  localparam int unsigned CNT_W = 32;
  // glitch filter defaults
  localparam int unsigned FILT_W = 16;
  localparam int unsigned FILT_LIMIT = 1000;
  // ---------------------------------------------------------------
  // register map (AXI4-Lite byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam int unsigned CTRL_VARIANT_LSB = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // attached option codes and state codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OPT_FLOAT = 2'b00,
    OPT_PULLUP = 2'b01,
    OPT_CAP = 2'b10,
    OPT_GROUND = 2'b11
  } opt_e;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_DETECT = 3'b001,
    ST_TIMED = 3'b010,
    ST_CHARGE = 3'b011,
    ST_LATCH = 3'b100,
    ST_RUN = 3'b101
  } state_e;
endpackage

//--- src/wsup_filter.sv
// glitch filter with overdrive-weighted integration
`timescale 1ns/1ps
`default_nettype none
module wsup_filter
  import wsup_pkg::*;
#(
  parameter int unsigned W = FILT_W,
  parameter logic [FILT_W-1:0] LIMIT = FILT_LIMIT[FILT_W-1:0]
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fault_in,
  input wire logic [1:0] overdrive,
  output logic fault_out
);
  logic [W-1:0] acc_reg;
  logic [W-1:0] step;
  // larger overdrive integrates faster; short spikes decay away
  assign step = W'(overdrive) + W'(1);
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (fault_in) begin
      acc_reg <= (acc_reg >= LIMIT - step) ? LIMIT : acc_reg + step;
    end else if (acc_reg != '0) begin
      acc_reg <= acc_reg - W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_out <= 1'b0;
    end else if (acc_reg == LIMIT) begin
      fault_out <= 1'b1;
    end else if (acc_reg == '0) begin
      fault_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- src/wsup_core.sv
// reset-output logic of the window supervisor with delay selection
// Operation
// RULE1 - release delay set by capacitor, pull-up or floating config pin
// RULE2 - state machine pulls config pin down and samples it for 450 us
// RULE3 - detection reruns each time sense enters the valid window
// RULE4 - floating selects short preset, pull-up the long preset
// RULE5 - fixed variant uses 50 us for both and has no capacitor mode
// RULE6 - capacitor discharged by pulldown while reset is asserted; here pulldown only in HOLD and during the DETECT probe
// RULE7 - capacitor mode charges then releases at comparator threshold
// RULE8 - grounded config pin selects latch mode; variant 3 here runs its fixed delay instead
// RULE9 - in latch mode a low reset stays low after window returns
// RULE10 - raising config pin while latched releases reset at once
// RULE11 - unlatch by driving config pin above 1.2 V via resistor
// RULE12 - reset asserted when sense below undervoltage or above overvoltage
// RULE13 - reset released only after release delay in window
// RULE14 - short excursions ignored; larger overdrive responds faster
// RULE15 - supply lockout holds reset low regardless of sense
// RULE16 - manual reset ignored while reset already low for other cause; here low MR still sends DETECT, TIMED and CHARGE back to HOLD
// RULE17 - comparisons are input bits; delay counted in clock cycles
// RULE18 - release counter restarts when any reset condition reappears
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wsup_core
  import wsup_pkg::*;
#(
  parameter int unsigned DETECT_CNT = DETECT_CYCLES,
  parameter int unsigned PROBE_CNT = PROBE_CYCLES,
  parameter int unsigned SHORT_V0 = SHORT_US_V0 * CLK_MHZ,
  parameter int unsigned LONG_V0 = LONG_US_V0 * CLK_MHZ,
  parameter int unsigned SHORT_V1 = SHORT_US_V1 * CLK_MHZ,
  parameter int unsigned LONG_V1 = LONG_US_V1 * CLK_MHZ,
  parameter int unsigned SHORT_V2 = SHORT_US_V2 * CLK_MHZ,
  parameter int unsigned LONG_V2 = LONG_US_V2 * CLK_MHZ,
  parameter int unsigned FIXED_V3 = FIXED_US_V3 * CLK_MHZ,
  parameter logic [FILT_W-1:0] FILTER_LIMIT = FILT_LIMIT[FILT_W-1:0]
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERVOLTAGE,
  input wire logic IN_WINDOW_HYST,
  input wire logic [1:0] OVERDRIVE,
  input wire logic SUPPLY_LOCKOUT,
  input wire logic MANUAL_RESET_N,
  input wire logic DELAY_CONFIG_PIN_HIGH,
  input wire logic DELAY_CAP_THRESHOLD,
  output logic DELAY_PULLDOWN_EN,
  output logic DELAY_CHARGE_CURRENT_EN,
  output logic RESET_N_O,
  output logic RESET_N_OE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {UNDERVOLTAGE, OVERVOLTAGE, IN_WINDOW_HYST,
                     SUPPLY_LOCKOUT, MANUAL_RESET_N,
                     DELAY_CONFIG_PIN_HIGH, DELAY_CAP_THRESHOLD};
  logic rst_any;
  assign rst_any = RST;
  // RULE17 comparator bits synced
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (rst_any) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  logic uv_s, ov_s, win_s, lock_s, mr_n_s, pin_s, cap_s;
  assign {uv_s, ov_s, win_s, lock_s, mr_n_s, pin_s, cap_s} = sync2_reg;
  // two stages like the fault bits, so size and fault stay aligned
  logic [1:0] od_meta_reg;
  logic [1:0] od_reg;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      od_meta_reg <= 2'b00;
      od_reg <= 2'b00;
    end else begin
      od_meta_reg <= OVERDRIVE;
      od_reg <= od_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // window fault filtering
  // ---------------------------------------------------------------
  logic fault_filt;
  // RULE14 filter transients
  wsup_filter #(
    .W(FILT_W),
    .LIMIT(FILTER_LIMIT)
  ) u_filter (
    .clk(REF_CLK),
    .rst(RST),
    .fault_in(uv_s | ov_s),
    .overdrive(od_reg),
    .fault_out(fault_filt)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0] variant_reg;
  state_e state_reg;
  opt_e opt_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic reset_n_reg;
  logic latched_reg;
  logic mr_cause;
  logic fault_cond;
  // RULE12 window violation
  // RULE15 supply lockout forces reset
  assign fault_cond = fault_filt | lock_s;
  // RULE16 mr_cause only while output is high or in ST_RUN; low MR also sends DETECT, TIMED and CHARGE back to HOLD
  assign mr_cause = ~mr_n_s & (reset_n_reg | state_reg == ST_RUN);

  // ---------------------------------------------------------------
  // delay selection
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] delay_cycles;
  always_comb begin
    delay_cycles = CNT_W'(FIXED_V3);
    case (variant_reg)
      // RULE4 short for floating, long for pull-up
      2'd0: delay_cycles = (opt_reg == OPT_PULLUP) ? CNT_W'(LONG_V0)
                                                   : CNT_W'(SHORT_V0);
      2'd1: delay_cycles = (opt_reg == OPT_PULLUP) ? CNT_W'(LONG_V1)
                                                   : CNT_W'(SHORT_V1);
      2'd2: delay_cycles = (opt_reg == OPT_PULLUP) ? CNT_W'(LONG_V2)
                                                   : CNT_W'(SHORT_V2);
      // RULE5 fixed variant
      default: delay_cycles = CNT_W'(FIXED_V3);
    endcase
  end

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  // pin sample at end of probe: high=pull-up; low after pulldown
  // released: cap charging keeps it low, floating reads its keeper
  logic probe_hi_reg;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= ST_HOLD;
      cnt_reg <= '0;
      opt_reg <= OPT_FLOAT;
      probe_hi_reg <= 1'b0;
      latched_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          cnt_reg <= '0;
          // RULE9 latch keeps reset low
          if (latched_reg) begin
            state_reg <= ST_LATCH;
          // RULE3 rerun detection on window entry
          end else if (win_s & ~fault_cond & mr_n_s) begin
            state_reg <= ST_DETECT;
          end
        end
        // RULE2 pulldown for the probe time, sample at probe end and at detection end
        ST_DETECT: begin
          if (fault_cond | ~mr_n_s) begin
            state_reg <= ST_HOLD;
            cnt_reg <= '0;
          end else if (cnt_reg == CNT_W'(PROBE_CNT - 1)) begin
            probe_hi_reg <= pin_s;
            cnt_reg <= cnt_reg + CNT_W'(1);
          end else if (cnt_reg >= CNT_W'(DETECT_CNT - 1)) begin
            cnt_reg <= '0;
            // RULE1 classify the attached option
            if (probe_hi_reg) begin
              opt_reg <= OPT_PULLUP;
              state_reg <= ST_TIMED;
            end else if (pin_s) begin
              opt_reg <= OPT_FLOAT;
              state_reg <= ST_TIMED;
            // RULE8 grounded pin selects latch in variants 0..2
            end else if (variant_reg != 2'd3 && cap_s) begin
              opt_reg <= OPT_CAP;
              state_reg <= ST_CHARGE;
            end else if (variant_reg == 2'd3) begin
              opt_reg <= OPT_FLOAT;
              state_reg <= ST_TIMED;
            end else begin
              opt_reg <= OPT_GROUND;
              latched_reg <= 1'b1;
              state_reg <= ST_LATCH;
            end
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        // RULE13 release after delay
        ST_TIMED: begin
          // RULE18 restart on reappearing condition
          if (fault_cond | ~mr_n_s) begin
            state_reg <= ST_HOLD;
            cnt_reg <= '0;
          end else if (cnt_reg >= delay_cycles - CNT_W'(1)) begin
            state_reg <= ST_RUN;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        // RULE7 charge until threshold reached
        ST_CHARGE: begin
          if (fault_cond | ~mr_n_s) begin
            state_reg <= ST_HOLD;
          end else if (cap_s) begin
            state_reg <= ST_RUN;
          end
        end
        // RULE10 raised pin releases at once
        ST_LATCH: begin
          if (pin_s) begin
            latched_reg <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault_cond | mr_cause) begin
            state_reg <= ST_HOLD;
            // RULE9 latched stays low
            if (opt_reg == OPT_GROUND & ~pin_s) begin
              latched_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_HOLD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      reset_n_reg <= 1'b0;
    end else begin
      reset_n_reg <= (state_reg == ST_RUN) & ~fault_cond & ~mr_cause;
    end
  end
  // open drain: drive low only
  assign RESET_N_O = 1'b0;
  assign RESET_N_OE = ~reset_n_reg;
  // RULE6 discharge in ST_HOLD and during the ST_DETECT probe
  assign DELAY_PULLDOWN_EN = (state_reg == ST_HOLD) |
    ((state_reg == ST_DETECT) & (cnt_reg < CNT_W'(PROBE_CNT)));
  // RULE7 charge current in capacitor mode
  assign DELAY_CHARGE_CURRENT_EN = (state_reg == ST_CHARGE);

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_reg, w_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  assign S_AXI_AWREADY = ~aw_reg & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_reg & ~S_AXI_BVALID;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      variant_reg <= CTRL_RESET[1:0];
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (aw_reg & w_reg) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (awaddr_reg == ADDR_CTRL) begin
          S_AXI_BRESP <= RESP_OKAY;
          if (wstrb_reg[0]) begin
            variant_reg <= wdata_reg[CTRL_VARIANT_LSB +: 2];
          end
        end else if (awaddr_reg == ADDR_STATUS ||
                     awaddr_reg == ADDR_DELAY) begin
          S_AXI_BRESP <= RESP_OKAY;
        end else begin
          S_AXI_BRESP <= RESP_SLVERR;
        end
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      case (S_AXI_ARADDR)
        ADDR_CTRL: S_AXI_RDATA <= {30'h0000_0000, variant_reg};
        ADDR_STATUS: S_AXI_RDATA <= {24'h00_0000, latched_reg,
          reset_n_reg, opt_reg, 1'b0, state_reg};
        ADDR_DELAY: S_AXI_RDATA <= delay_cycles;
        default: begin
          S_AXI_RDATA <= '0;
          S_AXI_RRESP <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/wsup_core_chk.sv
// assertions on the reset and bus ports of the supervisor core
`timescale 1ns/1ps
`default_nettype none
module wsup_core_chk (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERVOLTAGE,
  input wire logic [1:0] OVERDRIVE,
  input wire logic SUPPLY_LOCKOUT,
  input wire logic DELAY_PULLDOWN_EN,
  input wire logic DELAY_CHARGE_CURRENT_EN,
  input wire logic RESET_N_O,
  input wire logic RESET_N_OE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // reset output
  // ---------------------------------------------------------------
  property p_open_drain; RESET_N_O == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("reset pin driven high");
  // sync and filter latency covered by eight cycles
  property p_fault;
    ((UNDERVOLTAGE || OVERVOLTAGE) && OVERDRIVE == 2'd3)[*8] |-> RESET_N_OE;
  endproperty
  a_fault: assert property (p_fault)
    else $error("window fault did not assert reset");
  property p_lockout; SUPPLY_LOCKOUT[*5] |-> RESET_N_OE; endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout did not hold reset");
  property p_release;
    $fell(RESET_N_OE) |-> !$past(UNDERVOLTAGE, 4) && !$past(OVERVOLTAGE, 4);
  endproperty
  a_release: assert property (p_release)
    else $error("reset released during fault");
  property p_discharge; $rose(RESET_N_OE) |-> ##[0:2] DELAY_PULLDOWN_EN;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("no pulldown after reset asserted");
  property p_charge;
    DELAY_CHARGE_CURRENT_EN |-> RESET_N_OE && !DELAY_PULLDOWN_EN;
  endproperty
  a_charge: assert property (p_charge)
    else $error("charge source on outside reset delay");
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  property p_bresp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> ##1 S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write answer late");
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read answer late");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer changed while waiting");
  c_assert: cover property ($rose(RESET_N_OE));
  c_release: cover property ($fell(RESET_N_OE));
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule
`default_nettype wire

//--- tb/wsup_far_end.sv
// model of the config pin attachment and the reset line pull-up
`timescale 1ns/1ps
`default_nettype none
module wsup_far_end
  import wsup_pkg::*;
#(
  parameter int CAP_CNT = 60
) (
  input wire logic clk,
  input wire opt_e option,
  input wire logic unlatch,
  input wire logic pulldown_en,
  input wire logic charge_en,
  input wire logic reset_n_oe,
  output logic pin_high,
  output logic cap_thr,
  output logic reset_line
);
  int cap_cnt = 0;
  always_ff @(posedge clk) begin
    if (pulldown_en)
      cap_cnt <= 0;
    else if (charge_en)
      cap_cnt <= cap_cnt + 1;
  end
  assign cap_thr = (cap_cnt >= CAP_CNT);
  always_comb begin
    case (option)
      OPT_PULLUP: pin_high = 1'b1;
      OPT_FLOAT: pin_high = !pulldown_en;
      OPT_CAP: pin_high = cap_thr;
      default: pin_high = unlatch;
    endcase
  end
  // external pull-up when nobody pulls low
  assign reset_line = !reset_n_oe;
endmodule
`default_nettype wire

//--- tb/window_supervisor_reset_delay_tb.sv
// self-checking bench of the supervisor reset delay logic
`timescale 1ns/1ps
`default_nettype none
module window_supervisor_reset_delay_tb;
  import wsup_pkg::*;
  localparam int DET = 200;
  localparam int S0 = 100;
  localparam int L0 = 400;
  localparam int F3 = 50;
  logic clk = 0, rst = 1, uv = 1, ov = 0, inwin = 0, lock = 0, mr_n = 1;
  logic unlatch = 0, pd_en, chg_en, pin_high, cap_thr, rst_o, rst_oe, rline;
  logic [1:0] od = 2'd3, bresp, rresp;
  opt_e option = OPT_FLOAT;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata;
  int num_errors = 0, checked = 0;
  logic [1:0] wr_resp;
  always #2 clk = ~clk;
  wsup_core #(.DETECT_CNT(DET), .PROBE_CNT(20), .SHORT_V0(S0), .LONG_V0(L0),
    .FIXED_V3(F3), .FILTER_LIMIT(16'h0004)) u_dut (
    .REF_CLK(clk), .RST(rst), .UNDERVOLTAGE(uv), .OVERVOLTAGE(ov),
    .IN_WINDOW_HYST(inwin), .OVERDRIVE(od), .SUPPLY_LOCKOUT(lock),
    .MANUAL_RESET_N(mr_n), .DELAY_CONFIG_PIN_HIGH(pin_high),
    .DELAY_CAP_THRESHOLD(cap_thr), .DELAY_PULLDOWN_EN(pd_en),
    .DELAY_CHARGE_CURRENT_EN(chg_en), .RESET_N_O(rst_o),
    .RESET_N_OE(rst_oe), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  wsup_far_end u_far (.clk(clk), .option(option), .unlatch(unlatch),
    .pulldown_en(pd_en), .charge_en(chg_en), .reset_n_oe(rst_oe),
    .pin_high(pin_high), .cap_thr(cap_thr), .reset_line(rline));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit a_ok, w_ok;
    int t;
    {a_ok, w_ok, t} = 0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(a_ok && w_ok) && t < 200) begin
      @(posedge clk);
      t++;
      if (awready && !a_ok) begin
        a_ok = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      t++;
    end while (!bvalid && t < 200);
    wr_resp = bresp;
    bready <= 1'b0;
    // idle edge so a following call never reassigns a strobe at once
    @(posedge clk);
    if (t >= 200)
      num_errors++;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int t;
    t = 0;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge clk);
      t++;
    end while (!arready && t < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      t++;
    end while (!rvalid && t < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
    if (t >= 200)
      num_errors++;
  endtask
  // a window fault, then the sense back inside the window
  task automatic enter_window(input int len);
    uv <= 1'b1;
    inwin <= 1'b0;
    repeat (len) @(posedge clk);
    uv <= 1'b0;
    inwin <= 1'b1;
    @(posedge clk);
  endtask
  task automatic measure(input int lo, input int hi);
    int n;
    n = 0;
    while (rline !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check({31'd0, n >= lo && n <= hi}, 32'd1);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [1:0] rsp;
    int dly[4];
    dly = '{S0, L0, F3, F3};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_read(ADDR_CTRL, rd, rsp);
    check(rd, CTRL_RESET);
    axi_read(8'h0C, rd, rsp);
    check(rd, 32'h0000_0000);
    check(rsp, RESP_SLVERR);
    axi_write(8'h0C, 32'h0000_0001);
    check(wr_resp, RESP_SLVERR);
    axi_write(ADDR_CTRL, 32'h0000_0000);
    check(wr_resp, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      axi_write(ADDR_CTRL, (i < 2) ? 32'h0000_0000 : 32'h0000_0003);
      option <= (i % 2) ? OPT_PULLUP : OPT_FLOAT;
      enter_window(10);
      measure(DET + dly[i], DET + dly[i] + 40);
      axi_read(ADDR_DELAY, rd, rsp);
      check(rd, dly[i]);
    end
    $display("test presets done");
    axi_write(ADDR_CTRL, 32'h0000_0000);
    option <= OPT_FLOAT;
    enter_window(10);
    repeat (DET + 50) @(posedge clk);
    enter_window(10);
    measure(DET + S0, DET + S0 + 40);
    $display("test restart done");
    // short shallow dip must not reach the output
    od <= 2'd0;
    uv <= 1'b1;
    @(posedge clk);
    uv <= 1'b0;
    repeat (10) @(posedge clk);
    check(rline, 1'b1);
    od <= 2'd3;
    mr_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(rline, 1'b0);
    mr_n <= 1'b1;
    measure(S0, DET + S0 + 40);
    lock <= 1'b1;
    repeat (6) @(posedge clk);
    check(rline, 1'b0);
    lock <= 1'b0;
    measure(S0, DET + S0 + 40);
    $display("test manual and lockout done");
    option <= OPT_GROUND;
    enter_window(10);
    repeat (DET + L0 + 100) @(posedge clk);
    check(rline, 1'b0);
    unlatch <= 1'b1;
    repeat (8) @(posedge clk);
    check(rline, 1'b1);
    unlatch <= 1'b0;
    axi_read(ADDR_STATUS, rd, rsp);
    check(rd, {24'h00_0000, 1'b0, 1'b1, OPT_GROUND, 1'b0, ST_RUN});
    $display("test latch done");
    conclude();
  end
  initial begin
    #240000;
    num_errors++;
    conclude();
  end
endmodule
bind wsup_core wsup_core_chk u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .UNDERVOLTAGE(UNDERVOLTAGE), .OVERVOLTAGE(OVERVOLTAGE),
  .OVERDRIVE(OVERDRIVE), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT),
  .DELAY_PULLDOWN_EN(DELAY_PULLDOWN_EN),
  .DELAY_CHARGE_CURRENT_EN(DELAY_CHARGE_CURRENT_EN),
  .RESET_N_O(RESET_N_O), .RESET_N_OE(RESET_N_OE),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire
